// [scsp_port.sv]
// SPI slave control/status port of the analog die: one byte each way per frame.
// Assumes serial pins are asynchronous, event inputs are on clk_i, and a
// power-on reset input distinct from the system reset.
`timescale 1ns/1ps
`include "scsp_consts.svh"

// Functional notes
// - One byte each direction per transfer
// - Select fall drives output, snapshots status
// - Shift on clock rise, sample on fall
// - Valid only with exactly eight sample edges
// - Select rise loads received control byte
// - Output high impedance while select high
// - Control byte field layout D7 to D0
// - D7-D2 reset; pull-up only by power-on
// - Speed select encoding incl. low-power request
// - Pull-up option disconnects in Sleep/Stop
// - High-side enable bits switch outputs
// - Mode select encoding Sleep/Stop/clear/Run
// - Watchdog clear restarts watchdog, stays Run
// - Sleep needs two consecutive Sleep bytes
// - Stop needs two consecutive Stop bytes
// - Status byte field layout D7 to D0
// - Indicator set means bits show source
// - First read after reset shows battery fail
// - Regulator overtemp raises interrupt, sets bit
// - Bus flag clears on read; gates transmitter
// - Thermal recovery needs clearing read, then write
// - High sides one, two gated by PWM
module scsp_port
    import scsp_pkg::*;
(
    input wire logic clk_i,            // 250 MHz system clock
    input wire logic rstn_i,           // System reset, sync, active low
    input wire logic por_n_i,          // Power-on reset, sync, active low
    input wire logic serial_clock_pin, // Serial clock from master
    input wire logic sel_n_i,          // Slave select, active low
    input wire logic mosi_i,           // Master-out data
    output logic miso_o,               // Master-in data
    output logic miso_oe_o,            // Output enable for miso
    input wire scsp_evt_s evt_i,       // Analog events and levels
    input wire logic pwm_gate_input,   // PWM gate pin
    output logic hs1_on_o,             // High side one drive
    output logic hs2_on_o,             // High side two drive
    output logic hs3_on_o,             // High side three drive
    output logic [1:0] bus_speed_o,    // Bus slew selection
    output logic bus_pullup_on_o,      // Bus pull-up connected
    output logic bus_tx_en_o,          // Bus transmitter enable
    output logic [1:0] mode_o,         // Operating mode
    output logic wd_clear_o,           // Watchdog restart pulse
    output logic irq_o                 // Interrupt request
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic sck_prev;
        logic sel_prev;
        logic [7:0] rx;
        logic [7:0] tx;
        logic [`SCSP_CNT_W-1:0] cnt;
        logic [7:0] last_cmd;
        scsp_mode_e mode;
        scsp_ctl_s ctl;
        logic first_rd;
        logic hs_lock;
        logic [7:0] shot;
        logic miso;
        logic miso_oe;
        logic hs1;
        logic hs2;
        logic hs3;
        logic pullup_on;
        logic tx_en;
        logic wd_clr;
        logic irq;
    } scsp_port_s;

    scsp_port_s st_q;
    scsp_port_s st_d;

    logic sck_s;
    logic sel_n_s;
    logic mosi_s;
    logic pwm_s;
    logic bus_flag;
    logic ot_flag;
    logic hst_flag;
    logic clr_bus;
    logic clr_ot;
    logic clr_hst;
    logic [7:0] status_now;
    logic src_pend;
    logic rst_all_n;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Power-on reset also clears every helper flop
    assign rst_all_n = rstn_i & por_n_i;

    // Serial clock, idles low
    scsp_sync u_sync_sck (
        .clk_i(clk_i),
        .rstn_i(rst_all_n),
        .d_i(serial_clock_pin),
        .init_i(1'b0),
        .q_o(sck_s)
    );
    // Slave select, idles high so no false frame start
    scsp_sync u_sync_sel (
        .clk_i(clk_i),
        .rstn_i(rst_all_n),
        .d_i(sel_n_i),
        .init_i(1'b1),
        .q_o(sel_n_s)
    );
    // Master data, same latency as the clock
    scsp_sync u_sync_mosi (
        .clk_i(clk_i),
        .rstn_i(rst_all_n),
        .d_i(mosi_i),
        .init_i(1'b0),
        .q_o(mosi_s)
    );
    // PWM gate pin
    scsp_sync u_sync_pwm (
        .clk_i(clk_i),
        .rstn_i(rst_all_n),
        .d_i(pwm_gate_input),
        .init_i(1'b0),
        .q_o(pwm_s)
    );

    // ----------------------------------------
    // Sticky flags, cleared by a read that shipped them set
    // ----------------------------------------
    // Bus wake or fault; held while the fault persists
    scsp_flag u_flag_bus (
        .clk_i(clk_i),
        .rstn_i(rst_all_n),
        .set_i(evt_i.bus_wake | evt_i.bus_fault),
        .clr_i(clr_bus),
        .flag_o(bus_flag)
    );
    // Regulator over-temperature warning
    scsp_flag u_flag_ot (
        .clk_i(clk_i),
        .rstn_i(rst_all_n),
        .set_i(evt_i.reg_overtemp),
        .clr_i(clr_ot),
        .flag_o(ot_flag)
    );
    // High-side thermal shutdown
    scsp_flag u_flag_hst (
        .clk_i(clk_i),
        .rstn_i(rst_all_n),
        .set_i(evt_i.hs_thermal),
        .clr_i(clr_hst),
        .flag_o(hst_flag)
    );

    // Frame edges
    logic sel_fall;
    logic sel_rise;
    logic sck_rise;
    logic sck_fall;
    logic good_len;
    assign sel_fall = st_q.sel_prev & ~sel_n_s;
    assign sel_rise = ~st_q.sel_prev & sel_n_s;
    assign sck_rise = ~st_q.sck_prev & sck_s & ~sel_n_s;
    assign sck_fall = st_q.sck_prev & ~sck_s & ~sel_n_s;
    assign good_len = (st_q.cnt == `SCSP_CNT_W'(`SCSP_XFER_BITS));

    // Clears only after a complete frame that carried the flag set
    assign clr_bus = sel_rise & good_len & st_q.shot[`SCSP_ST_BUS] & ~evt_i.bus_fault;
    assign clr_ot = sel_rise & good_len & st_q.shot[`SCSP_ST_OT];
    assign clr_hst = sel_rise & good_len & st_q.shot[`SCSP_ST_HST];

    // Live status byte; indicator marks latched event source
    assign src_pend = bus_flag | ot_flag | hst_flag;
    always_comb begin
        status_now = 8'h00;
        status_now[`SCSP_ST_IRQ] = src_pend;
        status_now[`SCSP_ST_BUS] = bus_flag;
        status_now[`SCSP_ST_OV] = evt_i.over_volt;
        status_now[`SCSP_ST_UV] = st_q.first_rd ? evt_i.batt_fail : evt_i.under_volt;
        status_now[`SCSP_ST_OT] = ot_flag | evt_i.reg_overtemp;
        status_now[`SCSP_ST_HST] = hst_flag | evt_i.hs_thermal;
        status_now[`SCSP_ST_WK2] = evt_i.wake_two;
        status_now[`SCSP_ST_WK1] = evt_i.wake_one;
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.sck_prev = sck_s;
        st_d.sel_prev = sel_n_s;
        st_d.wd_clr = 1'b0;
        // Start of frame: drive output and freeze status
        if (sel_fall) begin
            st_d.shot = status_now;
            st_d.tx = status_now;
            st_d.cnt = '0;
            st_d.miso_oe = 1'b1;
            st_d.miso = status_now[7];
        end
        // Shift out on rise; first bit already presented
        if (sck_rise && st_q.cnt != '0) begin
            st_d.miso = st_q.tx[7];
        end
        // Sample on fall, count edges
        if (sck_fall) begin
            st_d.rx = {st_q.rx[6:0], mosi_s};
            st_d.tx = {st_q.tx[6:0], 1'b0};
            if (st_q.cnt != '1) begin
                st_d.cnt = st_q.cnt + `SCSP_CNT_W'(1);
            end
        end
        // End of frame
        if (sel_rise) begin
            st_d.miso_oe = 1'b0;
            st_d.miso = 1'b0;
            if (good_len) begin
                st_d.first_rd = 1'b0;
                st_d.ctl = st_q.rx;
                if (st_q.hs_lock && !hst_flag && !st_q.shot[`SCSP_ST_HST]) begin
                    st_d.hs_lock = 1'b0;
                end
                if (st_q.hs_lock && st_d.hs_lock) begin
                    st_d.ctl.hs1_en = 1'b0;
                    st_d.ctl.hs2_en = 1'b0;
                    st_d.ctl.hs3_en = 1'b0;
                end
                // Two-frame low-power entry
                if ((st_q.rx & `SCSP_SLEEP_CMD_MASK) == `SCSP_SLEEP_CMD
                    || (st_q.rx & `SCSP_SLEEP_CMD_MASK) == `SCSP_STOP_CMD) begin
                    if (st_q.mode == SCSP_ARMED && st_q.rx == st_q.last_cmd) begin
                        st_d.mode = (st_q.rx[0]) ? SCSP_STOP : SCSP_SLEEP;
                    end else begin
                        st_d.mode = SCSP_ARMED;
                    end
                end else begin
                    st_d.mode = SCSP_RUN;
                    if (st_q.rx[1:0] == `SCSP_OP_WDCLR) begin
                        st_d.wd_clr = 1'b1;
                    end
                end
                st_d.last_cmd = st_q.rx;
            end
        end
        // Thermal shutdown latches high sides off
        if (evt_i.hs_thermal) begin
            st_d.hs_lock = 1'b1;
            st_d.ctl.hs1_en = 1'b0;
            st_d.ctl.hs2_en = 1'b0;
            st_d.ctl.hs3_en = 1'b0;
        end
        // Output drives; low-power modes disable high sides
        st_d.hs1 = st_q.ctl.hs1_en & pwm_s & ~st_q.hs_lock & ~st_q.mode[1];
        st_d.hs2 = st_q.ctl.hs2_en & pwm_s & ~st_q.hs_lock & ~st_q.mode[1];
        st_d.hs3 = st_q.ctl.hs3_en & ~st_q.hs_lock & ~st_q.mode[1];
        st_d.pullup_on = ~(st_q.ctl.pullup_opt & st_q.mode[1]);
        st_d.tx_en = ~bus_flag & ~evt_i.bus_fault & ~st_q.mode[1];
        st_d.irq = src_pend;
    end

    // ----------------------------------------
    // Registers; system reset keeps pull-up option
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (!por_n_i || !rstn_i) begin
            st_q <= '0;
            st_q.sck_prev <= 1'b0;
            st_q.sel_prev <= 1'b1;
            st_q.ctl <= `SCSP_CTL_RST;
            st_q.ctl.pullup_opt <= por_n_i ? st_q.ctl.pullup_opt : 1'b0;
            st_q.mode <= SCSP_RUN;
            st_q.first_rd <= 1'b1;
            st_q.pullup_on <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------
    // Outputs straight from flops
    // ----------------------------------------
    assign miso_o = st_q.miso;
    assign miso_oe_o = st_q.miso_oe;
    assign hs1_on_o = st_q.hs1;
    assign hs2_on_o = st_q.hs2;
    assign hs3_on_o = st_q.hs3;
    assign bus_speed_o = st_q.ctl.speed;
    assign bus_pullup_on_o = st_q.pullup_on;
    assign bus_tx_en_o = st_q.tx_en;
    assign mode_o = st_q.mode;
    assign wd_clear_o = st_q.wd_clr;
    assign irq_o = st_q.irq;
endmodule

// [scsp_consts.svh]
// Constants for the SPI control/status port: bit positions, reset values, encodings.
// Assumes inclusion by bare name from the package and design modules.
`ifndef SCSP_CONSTS_SVH
`define SCSP_CONSTS_SVH

// ----------------------------------------
// Transfer length
// ----------------------------------------
`define SCSP_XFER_BITS 8
`define SCSP_CNT_W 4

// ----------------------------------------
// Control byte bit positions
// ----------------------------------------
`define SCSP_CTL_SPD_HI 7
`define SCSP_CTL_SPD_LO 6
`define SCSP_CTL_PU 5
`define SCSP_CTL_HS3 4
`define SCSP_CTL_HS2 3
`define SCSP_CTL_HS1 2
`define SCSP_CTL_OP_HI 1
`define SCSP_CTL_OP_LO 0

// ----------------------------------------
// Status byte bit positions
// ----------------------------------------
`define SCSP_ST_IRQ 7
`define SCSP_ST_BUS 6
`define SCSP_ST_OV 5
`define SCSP_ST_UV 4
`define SCSP_ST_OT 3
`define SCSP_ST_HST 2
`define SCSP_ST_WK2 1
`define SCSP_ST_WK1 0

// ----------------------------------------
// Encodings and reset values
// ----------------------------------------
`define SCSP_SPD_20K 2'h0
`define SCSP_SPD_10K 2'h1
`define SCSP_SPD_100K 2'h2
`define SCSP_SPD_LOWPWR 2'h3
`define SCSP_OP_SLEEP 2'h0
`define SCSP_OP_STOP 2'h1
`define SCSP_OP_WDCLR 2'h2
`define SCSP_OP_RUN 2'h3
`define SCSP_SLEEP_CMD_MASK 8'hDF
`define SCSP_SLEEP_CMD 8'hC0
`define SCSP_STOP_CMD 8'hC1
`define SCSP_CTL_RST 8'h03

`endif

// [scsp_pkg.sv]
// Types shared by the SPI control/status port modules.
// Assumes the constants header sits in the same folder.
`include "scsp_consts.svh"

package scsp_pkg;

    // ----------------------------------------
    // Modes and control fields
    // ----------------------------------------
    typedef enum logic [1:0] {
        SCSP_RUN   = 2'h0,
        SCSP_ARMED = 2'h1,
        SCSP_SLEEP = 2'h3,
        SCSP_STOP  = 2'h2
    } scsp_mode_e;

    typedef struct packed {
        logic [1:0] speed;
        logic pullup_opt;
        logic hs3_en;
        logic hs2_en;
        logic hs1_en;
        logic [1:0] op_sel;
    } scsp_ctl_s;

    // Raw fault and wake events from analog side
    typedef struct packed {
        logic bus_wake;
        logic bus_fault;
        logic over_volt;
        logic under_volt;
        logic batt_fail;
        logic reg_overtemp;
        logic hs_thermal;
        logic wake_two;
        logic wake_one;
    } scsp_evt_s;

endpackage

// [scsp_sync.sv]
// Two-stage synchroniser for one pin input.
// Assumes the input is asynchronous to clk_i.
`timescale 1ns/1ps

module scsp_sync (
    input wire logic clk_i,  // System clock
    input wire logic rstn_i, // Sync reset, active low
    input wire logic d_i,    // Async input
    input wire logic init_i, // Level taken at reset
    output logic q_o         // Synchronised level
);
    typedef struct packed {
        logic s1;
        logic s2;
    } scsp_sync_s;

    scsp_sync_s st_q;
    scsp_sync_s st_d;

    // Shift chain
    always_comb begin
        st_d.s1 = d_i;
        st_d.s2 = st_q.s1;
    end

    // Register chain
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st_q <= {init_i, init_i};
        end else begin
            st_q <= st_d;
        end
    end

    assign q_o = st_q.s2;
endmodule

// [scsp_flag.sv]
// Sticky status flag: set by an event, cleared by a read that saw it set.
// Assumes the event and clear are on clk_i.
`timescale 1ns/1ps

module scsp_flag (
    input wire logic clk_i,  // System clock
    input wire logic rstn_i, // Sync reset, active low
    input wire logic set_i,  // Event level or pulse
    input wire logic clr_i,  // Clear after read
    output logic flag_o      // Sticky flag
);
    logic flag_q;
    logic flag_d;

    // Set wins over clear
    always_comb begin
        flag_d = flag_q;
        if (clr_i) begin
            flag_d = 1'b0;
        end
        if (set_i) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag_o = flag_q;
endmodule

// [scsp_port_assertions.sv]
// Checker for the SPI control/status port, bound to its top module.
// Assumes both resets are synchronous on clk_i.
`timescale 1ns/1ps

module scsp_port_checker
    import scsp_pkg::*;
(
    input wire logic clk_i,          // System clock
    input wire logic rstn_i,         // System reset
    input wire logic por_n_i,        // Power-on reset
    input wire logic sel_n_i,        // Slave select
    input wire scsp_evt_s evt_i,     // Analog events
    input wire logic pwm_gate_input, // PWM gate pin
    input wire logic miso_oe_o,      // Reply enable
    input wire logic hs1_on_o,       // High side one
    input wire logic hs2_on_o,       // High side two
    input wire logic hs3_on_o,       // High side three
    input wire logic [1:0] bus_speed_o, // Slew select
    input wire logic bus_pullup_on_o,   // Pull-up connected
    input wire logic [1:0] mode_o,   // Operating mode
    input wire logic wd_clear_o,     // Watchdog pulse
    input wire logic irq_o           // Interrupt
);
    // ----------------------------------------
    // Shared timing and sequences
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i || !por_n_i);
    sequence sel_idle_s; sel_n_i [*6]; endsequence
    sequence sel_busy_s; !sel_n_i [*6]; endsequence
    sequence lowpwr_s; (mode_o == SCSP_SLEEP || mode_o == SCSP_STOP); endsequence
    sequence lowpwr_entry_s; $changed(mode_o) ##0 lowpwr_s; endsequence

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    miso_idle_a: assert property (sel_idle_s |-> !miso_oe_o)
        else $error("reply driven while deselected");
    miso_drive_a: assert property (sel_busy_s |-> miso_oe_o)
        else $error("reply not driven in frame");
    wd_pulse_a: assert property (wd_clear_o |-> (mode_o == SCSP_RUN) ##1 !wd_clear_o)
        else $error("watchdog pulse too long");
    lowpwr_order_a: assert property (lowpwr_entry_s |-> $past(mode_o) == SCSP_ARMED)
        else $error("low power without first command");
    ctl_at_end_a: assert property ($changed(bus_speed_o) |-> sel_n_i)
        else $error("control changed inside frame");
    mode_at_end_a: assert property ($changed(mode_o) |-> sel_n_i)
        else $error("mode changed inside frame");
    pwm_gate_a: assert property (!pwm_gate_input [*5] |-> !hs1_on_o && !hs2_on_o)
        else $error("high side on with gate low");
    lowpwr_hs_a: assert property (lowpwr_s [*2] |-> !(hs1_on_o || hs2_on_o || hs3_on_o))
        else $error("high side on in low power");
    pullup_off_a: assert property (!bus_pullup_on_o |-> $past(mode_o[1]))
        else $error("pull-up off outside low power");
    ot_irq_a: assert property ($rose(evt_i.reg_overtemp) |-> ##[1:3] irq_o)
        else $error("no interrupt on overtemp");
endmodule

bind scsp_port scsp_port_checker i_scsp_port_checker (.clk_i, .rstn_i, .por_n_i, .sel_n_i, .evt_i,
    .pwm_gate_input, .miso_oe_o, .hs1_on_o, .hs2_on_o, .hs3_on_o, .bus_speed_o, .bus_pullup_on_o,
    .mode_o, .wd_clear_o, .irq_o);

// [scsp_master.sv]
// Bus master model: one frame per call, half period of 20 system clocks.
// Assumes the caller enters the task just after a falling clock edge.
`timescale 1ns/1ps

module scsp_master (
    input wire logic clk_i,     // Pacing clock
    input wire logic miso_i,    // Reply data
    input wire logic miso_oe_i, // Reply enable
    output logic sck_o,         // Serial clock, still outside frames
    output logic sel_n_o,       // Slave select
    output logic mosi_o         // Command data
);
    initial begin
        sck_o = 1'b0;
        sel_n_o = 1'b1;
        mosi_o = 1'b0;
    end

    // Half serial period, 80 ns
    task automatic half;
        repeat (20) @(negedge clk_i);
    endtask

    // One frame of nb sample edges, MSB first
    task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
        logic [7:0] sh;
        sh = tx;
        rx = 8'h00;
        sel_n_o = 1'b0;
        mosi_o = sh[7];
        half();
        for (int i = 0; i < nb; i++) begin
            sck_o = 1'b1;
            if (i > 0) begin
                sh = {sh[6:0], ~sh[7]};
                mosi_o = sh[7];
            end
            half();
            sck_o = 1'b0;
            rx = {rx[6:0], miso_oe_i ? miso_i : 1'bx};
            half();
        end
        sel_n_o = 1'b1;
        mosi_o = ~mosi_o; // Released line shows no stale value
    endtask
endmodule

// [tb_top.sv]
// Self-checking bench for the SPI control/status port.
// Assumes the master model and the bound checker are compiled alongside.
`timescale 1ns/1ps

module tb_top;
    import scsp_pkg::*;
    logic clk_i = 1'b0, rstn_i = 1'b0, por_n_i = 1'b0, pwm_gate_input = 1'b1;
    scsp_evt_s evt_i = '0;
    logic serial_clock_pin, sel_n_i, mosi_i, miso_o, miso_oe_o, hs1_on_o, hs2_on_o, hs3_on_o;
    logic bus_pullup_on_o, bus_tx_en_o, wd_clear_o, irq_o;
    logic [1:0] bus_speed_o, mode_o;
    logic [7:0] rx;
    int num_errors = 0, compares = 0, wd_cnt = 0;

    // ----------------------------------------
    // Clock, instances, pulse counter
    // ----------------------------------------
    initial forever #2 clk_i = ~clk_i;
    always @(posedge clk_i) if (wd_clear_o) wd_cnt++;
    scsp_port i_scsp_port (.clk_i, .rstn_i, .por_n_i, .serial_clock_pin, .sel_n_i, .mosi_i, .miso_o,
        .miso_oe_o, .evt_i, .pwm_gate_input, .hs1_on_o, .hs2_on_o, .hs3_on_o, .bus_speed_o,
        .bus_pullup_on_o, .bus_tx_en_o, .mode_o, .wd_clear_o, .irq_o);
    scsp_master i_scsp_master (.clk_i, .miso_i(miso_o), .miso_oe_i(miso_oe_o), .sck_o(serial_clock_pin),
        .sel_n_o(sel_n_i), .mosi_o(mosi_i));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(input logic [7:0] tx, input int nb = 8);
        i_scsp_master.xfer(tx, nb, rx);
        repeat (10) @(negedge clk_i);
    endtask
    task automatic outs(input logic [7:0] exp);
        chk("outputs", exp, {bus_speed_o, bus_pullup_on_o, hs3_on_o, hs2_on_o, hs1_on_o, mode_o});
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic conclude;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #300000;
        num_errors++;
        conclude();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        evt_i.batt_fail = 1'b1;
        wait_n(4);
        rstn_i = 1'b1;
        por_n_i = 1'b1;
        wait_n(4);
        outs(8'h20);
        xfer(8'h5E);
        chk("battery fail", 8'h10, rx & 8'h10);
        outs(8'h7C);
        chk("watchdog pulses", 8'h01, wd_cnt[7:0]);
        pwm_gate_input = 1'b0;
        wait_n(8);
        outs(8'h70);
        pwm_gate_input = 1'b1;
        for (int s = 0; s < 4; s++) begin
            xfer({s[1:0], 6'h1F});
            outs({s[1:0], 6'h3C});
        end
        chk("watchdog pulses", 8'h01, wd_cnt[7:0]);
        xfer(8'h00, 7);
        outs(8'hFC);
        xfer(8'h00, 9);
        outs(8'hFC);
        evt_i.reg_overtemp = 1'b1;
        wait_n(4);
        evt_i.reg_overtemp = 1'b0;
        wait_n(4);
        chk("interrupt", 8'h01, {7'h00, irq_o});
        xfer(8'hDF);
        chk("overtemp source", 8'h88, rx & 8'h98);
        evt_i.batt_fail = 1'b0;
        chk("interrupt", 8'h00, {7'h00, irq_o});
        evt_i.bus_fault = 1'b1;
        wait_n(4);
        evt_i.bus_fault = 1'b0;
        wait_n(4);
        chk("transmitter", 8'h00, {7'h00, bus_tx_en_o});
        xfer(8'hDF);
        chk("bus flag", 8'h40, rx & 8'h40);
        chk("transmitter", 8'h01, {7'h00, bus_tx_en_o});
        evt_i.hs_thermal = 1'b1;
        wait_n(4);
        evt_i.hs_thermal = 1'b0;
        wait_n(4);
        outs(8'hE0);
        xfer(8'hDF);
        chk("thermal flag", 8'h04, rx & 8'h04);
        outs(8'hE0);
        xfer(8'hDF);
        outs(8'hFC);
        xfer(8'hC1);
        outs(8'hE1);
        xfer(8'hDF);
        outs(8'hFC);
        xfer(8'hE0);
        xfer(8'hE0);
        outs(8'hC3);
        rstn_i = 1'b0;
        wait_n(4);
        rstn_i = 1'b1;
        wait_n(4);
        outs(8'h20);
        xfer(8'hC1);
        xfer(8'hC1);
        outs(8'hE2);
        conclude();
    end
endmodule
